// ---- design/iox_expander.sv ----
// Purpose: serial-bus slave with sixteen I/O pins and a change interrupt
// Assumes: clk_link oversamples the bus lines, clk_sys runs the registers
// Notes: link bytes reach registers through a handshake and a FIFO
`timescale 1ns/1ps
`default_nettype none
module iox_expander
  import iox_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic [7:0] port_zero_pins_i,
  output logic [7:0] port_zero_pins_o,
  output logic [7:0] port_zero_pins_oe,
  input wire logic [7:0] port_one_pins_i,
  output logic [7:0] port_one_pins_o,
  output logic [7:0] port_one_pins_oe,
  output logic irq_o,
  output logic irq_oe,
  input wire logic apply_hold
);
  // ----------------------------------------------------------------
  // crossing signals
  // ----------------------------------------------------------------
  logic ev_tgl_reg;
  logic [8:0] ev_data_reg;
  logic rd_tgl_reg;
  logic ev_ack_reg;
  logic rd_ack_reg;
  logic [7:0] rd_data_reg;

  // ----------------------------------------------------------------
  // link domain: reset release and synchronisers
  // ----------------------------------------------------------------
  logic lrst_meta_reg;
  logic lrstn_reg;
  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      lrst_meta_reg <= 1'b0;
      lrstn_reg <= 1'b0;
    end else begin
      lrst_meta_reg <= 1'b1;
      lrstn_reg <= lrst_meta_reg;
    end
  end

  logic scl_meta_reg, scl_s_reg, scl_d_reg;
  logic sda_meta_reg, sda_s_reg, sda_d_reg;
  logic [2:0] strap_meta_reg, strap_s_reg;
  logic ev_ack_meta_reg, ev_ack_s_reg;
  logic rd_ack_meta_reg, rd_ack_s_reg, rd_ack_d_reg;
  always_ff @(posedge clk_link or negedge lrstn_reg) begin
    if (!lrstn_reg) begin
      scl_meta_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      strap_meta_reg <= 3'h0;
      strap_s_reg <= 3'h0;
      ev_ack_meta_reg <= 1'b0;
      ev_ack_s_reg <= 1'b0;
      rd_ack_meta_reg <= 1'b0;
      rd_ack_s_reg <= 1'b0;
      rd_ack_d_reg <= 1'b0;
    end else begin
      scl_meta_reg <= scl_i;
      scl_s_reg <= scl_meta_reg;
      scl_d_reg <= scl_s_reg;
      sda_meta_reg <= sda_i;
      sda_s_reg <= sda_meta_reg;
      sda_d_reg <= sda_s_reg;
      // straps are static, sampling them continuously is harmless
      strap_meta_reg <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
      strap_s_reg <= strap_meta_reg;
      ev_ack_meta_reg <= ev_ack_reg;
      ev_ack_s_reg <= ev_ack_meta_reg;
      rd_ack_meta_reg <= rd_ack_reg;
      rd_ack_s_reg <= rd_ack_meta_reg;
      rd_ack_d_reg <= rd_ack_s_reg;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det, ev_busy, addr_ok;
  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_det = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  assign ev_busy = (ev_tgl_reg != ev_ack_s_reg);

  function automatic logic [6:0] ev_addr_bits(input logic [7:0] b);
    return b[7:1];
  endfunction

  // ----------------------------------------------------------------
  // link domain: slave bit engine
  // ----------------------------------------------------------------
  iox_link_state_type st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  assign addr_ok = (ev_addr_bits(shift_reg) == {IOX_ADDR_FIXED, strap_s_reg});
  logic [7:0] tx_reg, tx_next;
  logic sda_oe_reg, sda_oe_next;
  logic sda_o_reg;
  logic ev_tgl_next, rd_tgl_next;
  logic [8:0] ev_data_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    sda_oe_next = sda_oe_reg;
    ev_tgl_next = ev_tgl_reg;
    ev_data_next = ev_data_reg;
    rd_tgl_next = rd_tgl_reg;
    // read byte stands still once its toggle is seen
    if (rd_ack_s_reg != rd_ack_d_reg) begin
      tx_next = rd_data_reg;
    end
    if (start_det) begin
      st_next = IOX_ST_ADDR;
      cnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end else if (stop_det) begin
      st_next = IOX_ST_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      case (st_reg)
        IOX_ST_ADDR: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == IOX_BITS_PER_BYTE) begin
            if (addr_ok && (shift_reg[0] || !ev_busy)) begin
              sda_oe_next = 1'b1;
              st_next = IOX_ST_ACK_ADDR;
              if (shift_reg[0]) begin
                rd_tgl_next = ~rd_tgl_reg;
              end else begin
                ev_tgl_next = ~ev_tgl_reg;
                ev_data_next = {IOX_EV_START, 8'h00};
              end
            end else begin
              st_next = IOX_ST_IDLE;
            end
          end
        end
        IOX_ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (shift_reg[0]) begin
              sda_oe_next = ~tx_reg[7];
              shift_next = {tx_reg[6:0], 1'b0};
              cnt_next = 4'h1;
              st_next = IOX_ST_TX;
            end else begin
              sda_oe_next = 1'b0;
              cnt_next = 4'h0;
              st_next = IOX_ST_RX;
            end
          end
        end
        IOX_ST_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == IOX_BITS_PER_BYTE) begin
            // full path toward registers: refuse the byte
            if (!ev_busy) begin
              sda_oe_next = 1'b1;
              ev_tgl_next = ~ev_tgl_reg;
              ev_data_next = {IOX_EV_DATA, shift_reg};
              st_next = IOX_ST_ACK_RX;
            end else begin
              st_next = IOX_ST_IDLE;
            end
          end
        end
        IOX_ST_ACK_RX: begin
          if (scl_fall) begin
            sda_oe_next = 1'b0;
            cnt_next = 4'h0;
            st_next = IOX_ST_RX;
          end
        end
        IOX_ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg == IOX_BITS_PER_BYTE) begin
              sda_oe_next = 1'b0;
              st_next = IOX_ST_MACK;
            end else begin
              sda_oe_next = ~shift_reg[7];
              shift_next = {shift_reg[6:0], 1'b0};
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        IOX_ST_MACK: begin
          if (scl_rise) begin
            if (sda_s_reg) begin
              st_next = IOX_ST_IDLE;
            end else begin
              rd_tgl_next = ~rd_tgl_reg;
            end
          end else if (scl_fall) begin
            sda_oe_next = ~tx_reg[7];
            shift_next = {tx_reg[6:0], 1'b0};
            cnt_next = 4'h1;
            st_next = IOX_ST_TX;
          end
        end
        default: begin
          st_next = IOX_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link or negedge lrstn_reg) begin
    if (!lrstn_reg) begin
      st_reg <= IOX_ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hff;
      sda_oe_reg <= 1'b0;
      sda_o_reg <= 1'b0;
      ev_tgl_reg <= 1'b0;
      ev_data_reg <= 9'h000;
      rd_tgl_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      sda_oe_reg <= sda_oe_next;
      sda_o_reg <= 1'b0;
      ev_tgl_reg <= ev_tgl_next;
      ev_data_reg <= ev_data_next;
      rd_tgl_reg <= rd_tgl_next;
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe = sda_oe_reg;

  a_start_to_addr: assert property (@(posedge clk_link) disable iff (!lrstn_reg)
    start_det |=> st_reg == IOX_ST_ADDR && !sda_oe_reg)
    else $error("start did not open address phase");
  a_stop_to_idle: assert property (@(posedge clk_link) disable iff (!lrstn_reg)
    stop_det |=> st_reg == IOX_ST_IDLE && !sda_oe_reg)
    else $error("stop did not return to idle");
  a_drive_on_fall: assert property (@(posedge clk_link) disable iff (!lrstn_reg)
    $rose(sda_oe_reg) |-> $past(scl_fall))
    else $error("data line pulled low off a clock fall");
  a_addr_mismatch_nack: assert property (@(posedge clk_link) disable iff (!lrstn_reg)
    st_reg == IOX_ST_ADDR && scl_fall && cnt_reg == 4'h8 && !addr_ok
    |=> st_reg == IOX_ST_IDLE && !sda_oe_reg)
    else $error("foreign address acknowledged");
  a_addr_match_ack: assert property (@(posedge clk_link) disable iff (!lrstn_reg)
    st_reg == IOX_ST_ADDR && scl_fall && cnt_reg == 4'h8 && addr_ok && shift_reg[0]
    |=> sda_oe_reg ##1 sda_oe_reg [*2])
    else $error("own read address not acknowledged");
  c_read_byte: cover property (@(posedge clk_link) disable iff (!lrstn_reg)
    st_reg == IOX_ST_TX ##[1:1000] st_reg == IOX_ST_MACK);

  // ----------------------------------------------------------------
  // system domain: synchronisers and event capture
  // ----------------------------------------------------------------
  logic ev_tgl_meta_reg, ev_tgl_s_reg, rd_tgl_meta_reg, rd_tgl_s_reg;
  logic [15:0] pin_meta_reg, pin_s_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ev_tgl_meta_reg <= 1'b0;
      ev_tgl_s_reg <= 1'b0;
      rd_tgl_meta_reg <= 1'b0;
      rd_tgl_s_reg <= 1'b0;
      pin_meta_reg <= 16'h0000;
      pin_s_reg <= 16'h0000;
    end else begin
      ev_tgl_meta_reg <= ev_tgl_reg;
      ev_tgl_s_reg <= ev_tgl_meta_reg;
      rd_tgl_meta_reg <= rd_tgl_reg;
      rd_tgl_s_reg <= rd_tgl_meta_reg;
      pin_meta_reg <= {port_one_pins_i, port_zero_pins_i};
      pin_s_reg <= pin_meta_reg;
    end
  end

  logic [1:0] init_cnt_reg;
  logic ev_pend, ev_push, fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_pop, rd_serve;
  logic [8:0] fifo_out_data;
  assign ev_pend = (ev_tgl_s_reg != ev_ack_reg);
  assign ev_push = ev_pend & fifo_in_ready;
  assign fifo_out_ready = ~apply_hold & (init_cnt_reg == 2'h0);
  assign fifo_pop = fifo_out_valid & fifo_out_ready;
  // reads wait for earlier writes so a pointer byte lands first
  assign rd_serve = (rd_tgl_s_reg != rd_ack_reg) & ~fifo_out_valid & ~ev_pend &
                    (init_cnt_reg == 2'h0);

  iox_fifo #(
    .WIDTH(IOX_FIFO_WIDTH),
    .DEPTH(IOX_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(ev_pend),
    .in_ready(fifo_in_ready),
    .in_data(ev_data_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // system domain: register file, pins, interrupt
  // ----------------------------------------------------------------
  logic [15:0] out_reg, out_next, pol_reg, pol_next, cfg_reg, cfg_next;
  logic [15:0] oe_reg, oe_next, snap_reg, snap_next, mismatch;
  logic [2:0] ptr_reg, ptr_next;
  logic expect_ptr_reg, expect_ptr_next, ev_ack_next, rd_ack_next, irq_oe_next, irq_o_reg;
  logic [7:0] rd_data_next;
  logic [1:0] init_cnt_next;

  assign mismatch = cfg_reg & (pin_s_reg ^ snap_reg);

  always_comb begin
    out_next = out_reg;
    pol_next = pol_reg;
    cfg_next = cfg_reg;
    snap_next = snap_reg;
    ptr_next = ptr_reg;
    expect_ptr_next = expect_ptr_reg;
    rd_data_next = rd_data_reg;
    rd_ack_next = rd_ack_reg;
    ev_ack_next = ev_ack_reg ^ ev_push;
    init_cnt_next = init_cnt_reg;
    if (init_cnt_reg != 2'h0) begin
      init_cnt_next = init_cnt_reg - 2'h1;
      snap_next = pin_s_reg;
    end
    if (fifo_pop) begin
      if (fifo_out_data[8] == IOX_EV_START) begin
        expect_ptr_next = 1'b1;
      end else if (expect_ptr_reg) begin
        ptr_next = fifo_out_data[2:0];
        expect_ptr_next = 1'b0;
      end else begin
        // writes to the input pair are dropped
        if (ptr_reg[2:1] == IOX_GRP_OUT) begin
          out_next = iox_put_byte(out_reg, ptr_reg[0], fifo_out_data[7:0]);
        end else if (ptr_reg[2:1] == IOX_GRP_POL) begin
          pol_next = iox_put_byte(pol_reg, ptr_reg[0], fifo_out_data[7:0]);
        end else if (ptr_reg[2:1] == IOX_GRP_CFG) begin
          cfg_next = iox_put_byte(cfg_reg, ptr_reg[0], fifo_out_data[7:0]);
        end
        ptr_next = iox_pair_next(ptr_reg);
      end
    end else if (rd_serve) begin
      if (ptr_reg[2:1] == IOX_GRP_IN) begin
        rd_data_next = iox_get_byte(pin_s_reg ^ pol_reg, ptr_reg[0]);
        snap_next = iox_put_byte(snap_reg, ptr_reg[0], iox_get_byte(pin_s_reg, ptr_reg[0]));
      end else if (ptr_reg[2:1] == IOX_GRP_OUT) begin
        rd_data_next = iox_get_byte(out_reg, ptr_reg[0]);
      end else if (ptr_reg[2:1] == IOX_GRP_POL) begin
        rd_data_next = iox_get_byte(pol_reg, ptr_reg[0]);
      end else begin
        rd_data_next = iox_get_byte(cfg_reg, ptr_reg[0]);
      end
      ptr_next = iox_pair_next(ptr_reg);
      rd_ack_next = ~rd_ack_reg;
    end
    oe_next = ~cfg_next;
    // follows the compare, so a pin that returns drops it again
    irq_oe_next = (init_cnt_reg == 2'h0) & (|mismatch);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_reg <= IOX_OUT_RST;
      pol_reg <= IOX_POL_RST;
      cfg_reg <= IOX_CFG_RST;
      oe_reg <= ~IOX_CFG_RST;
      snap_reg <= IOX_SNAP_RST;
      ptr_reg <= IOX_PTR_RST;
      expect_ptr_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      rd_ack_reg <= 1'b0;
      ev_ack_reg <= 1'b0;
      irq_oe <= 1'b0;
      irq_o_reg <= 1'b0;
      init_cnt_reg <= IOX_INIT_CYCLES;
    end else begin
      out_reg <= out_next;
      pol_reg <= pol_next;
      cfg_reg <= cfg_next;
      oe_reg <= oe_next;
      snap_reg <= snap_next;
      ptr_reg <= ptr_next;
      expect_ptr_reg <= expect_ptr_next;
      rd_data_reg <= rd_data_next;
      rd_ack_reg <= rd_ack_next;
      ev_ack_reg <= ev_ack_next;
      irq_oe <= irq_oe_next;
      irq_o_reg <= 1'b0;
      init_cnt_reg <= init_cnt_next;
    end
  end

  assign port_zero_pins_o = out_reg[7:0];
  assign port_one_pins_o = out_reg[15:8];
  assign port_zero_pins_oe = oe_reg[7:0];
  assign port_one_pins_oe = oe_reg[15:8];
  assign irq_o = irq_o_reg;

  a_cfg_sets_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
    fifo_pop && fifo_out_data[8] == IOX_EV_DATA && !expect_ptr_reg &&
    ptr_reg[2:1] == IOX_GRP_CFG
    |=> iox_get_byte(oe_reg, $past(ptr_reg[0])) == ~$past(fifo_out_data[7:0]))
    else $error("pin drive enable disagrees with direction");
  a_irq_on_change: assert property (@(posedge clk_sys) disable iff (!rstn)
    init_cnt_reg == 2'h0 && (|mismatch) |=> irq_oe)
    else $error("changed input did not raise interrupt");
  a_irq_release: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(|mismatch) |=> !irq_oe)
    else $error("interrupt held with no mismatch");
  a_read_clears_port: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_serve && ptr_reg == IOX_CMD_IN0
    |=> snap_reg[7:0] == $past(pin_s_reg[7:0]) && snap_reg[15:8] == $past(snap_reg[15:8]))
    else $error("port read touched wrong held value");
  a_ptr_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    fifo_pop && fifo_out_data[8] == IOX_EV_DATA && expect_ptr_reg
    |=> ptr_reg == $past(fifo_out_data[2:0]) && !expect_ptr_reg)
    else $error("pointer byte not loaded");
  a_reset_defaults: assert property (@(posedge clk_sys) disable iff (!rstn)
    init_cnt_reg != 2'h0 |-> out_reg == IOX_OUT_RST && cfg_reg == IOX_CFG_RST &&
    pol_reg == IOX_POL_RST)
    else $error("registers not at defaults after reset");
  c_cfg_write: cover property (@(posedge clk_sys) disable iff (!rstn) cfg_reg != $past(cfg_reg));
  c_irq_raise: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(irq_oe));
  c_port1_read: cover property (@(posedge clk_sys) disable iff (!rstn)
    rd_serve && ptr_reg == IOX_CMD_IN1);
endmodule
`default_nettype wire

// ---- design/iox_pkg.sv ----
// Purpose: constants, types and helpers for the sixteen-pin serial-bus I/O expander
// Assumes: bus sampling clock far faster than the serial clock
// Notes: imported by iox_expander only, which passes the FIFO sizes to iox_fifo
// Notes on behaviour
// - device acts only as bus slave
// - bits sampled and shifted by serial clock
// - data line open-drain, pull low only
// - strap pins match three address bits
// - sixteen pins, per-pin direction, two ports
// - input pin: both drivers off
// - output pin: push-pull driver enabled
// - input differing from held value raises interrupt
// - interrupt drops when input returns
// - reading a port clears only its interrupt
// - output-to-input switch may raise interrupt
// - START/STOP from data edge, clock high
// - address 0100 plus straps, last bit read
// - first byte is register pointer 0 to 7
// - reset loads defaults into all registers
package iox_pkg;
  // ----------------------------------------------------------------
  // sizes and framing
  // ----------------------------------------------------------------
  localparam int IOX_FIFO_DEPTH = 32;
  localparam int IOX_FIFO_WIDTH = 9;
  localparam logic [3:0] IOX_ADDR_FIXED = 4'h4;
  localparam logic [3:0] IOX_BITS_PER_BYTE = 4'h8;
  localparam logic IOX_EV_START = 1'b0;
  localparam logic IOX_EV_DATA = 1'b1;
  localparam logic [1:0] IOX_INIT_CYCLES = 2'h3;
  // ----------------------------------------------------------------
  // register pointer codes and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] IOX_CMD_IN0 = 3'h0;
  localparam logic [2:0] IOX_CMD_IN1 = 3'h1;
  localparam logic [2:0] IOX_PTR_RST = 3'h0;
  localparam logic [1:0] IOX_GRP_IN = 2'h0;
  localparam logic [1:0] IOX_GRP_OUT = 2'h1;
  localparam logic [1:0] IOX_GRP_POL = 2'h2;
  localparam logic [1:0] IOX_GRP_CFG = 2'h3;
  localparam logic [15:0] IOX_OUT_RST = 16'hffff;
  localparam logic [15:0] IOX_POL_RST = 16'h0000;
  localparam logic [15:0] IOX_CFG_RST = 16'hffff;
  localparam logic [15:0] IOX_SNAP_RST = 16'h0000;

  typedef enum logic [2:0] {
    IOX_ST_IDLE,
    IOX_ST_ADDR,
    IOX_ST_ACK_ADDR,
    IOX_ST_RX,
    IOX_ST_ACK_RX,
    IOX_ST_TX,
    IOX_ST_MACK
  } iox_link_state_type;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pointer stays inside its port pair
  function automatic logic [2:0] iox_pair_next(input logic [2:0] p);
    return {p[2:1], ~p[0]};
  endfunction

  function automatic logic [7:0] iox_get_byte(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction

  function automatic logic [15:0] iox_put_byte(input logic [15:0] v, input logic hi,
                                               input logic [7:0] b);
    return hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction
endpackage

// ---- design/iox_fifo.sv ----
// Purpose: synchronous FIFO between link event capture and register update
// Assumes: one clock, one reset
// Notes: full and empty from pointers with a wrap bit
`timescale 1ns/1ps
`default_nettype none
module iox_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] wr_next;
  logic [AW:0] rd_reg;
  logic [AW:0] rd_next;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty = (wr_reg == rd_reg);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem_reg[rd_reg[AW-1:0]];
  assign push = in_valid & ~full;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // storage needs no reset, nothing reads an empty slot
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data;
    end
  end

  a_full_holds_ptr: assert property (@(posedge clk_sys) disable iff (!rstn)
    full && in_valid |=> wr_reg == $past(wr_reg))
    else $error("fifo write pointer moved while full");
  c_fifo_full: cover property (@(posedge clk_sys) disable iff (!rstn) full);
endmodule
`default_nettype wire

// ---- verification/iox_bus_master.sv ----
// Purpose: serial-bus master model for the expander bench
// Assumes: pull-up on the data line, clock driven by this model only
// Notes: every phase is a fraction or multiple of HALF_NS
`timescale 1ns/1ps
`default_nettype none
module iox_bus_master #(
  parameter int HALF_NS = 1100
) (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // data moves a quarter into the low phase, clear of the synced clock fall
  task automatic start();
    #(HALF_NS/4) sda_pull = 1'b0;
    #(HALF_NS*3/4) scl = 1'b1;
    #(HALF_NS) sda_pull = 1'b1;
    #(HALF_NS) scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF_NS/4) sda_pull = 1'b1;
    #(HALF_NS*3/4) scl = 1'b1;
    #(HALF_NS) sda_pull = 1'b0;
    #(HALF_NS*2);
  endtask
  task automatic bit_io(input logic b, output logic r);
    #(HALF_NS/4) sda_pull = ~b;
    #(HALF_NS*3/4) scl = 1'b1;
    #(HALF_NS/2) r = sda_line;
    #(HALF_NS/2) scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(~mack, r);
  endtask
endmodule
`default_nettype wire

// ---- verification/iox_expander_tb.sv ----
// Purpose: self-checking bench for iox_expander
// Assumes: straps at 101, so write address 4a and read address 4b
// Notes: apply_hold stalls register updates to fill the FIFO
`timescale 1ns/1ps
`default_nettype none
module iox_expander_tb;
  logic clk_sys, clk_link, rstn, apply_hold, sda_o, sda_oe, irq_o, irq_oe, ack, ok;
  logic scl, sda_pull;
  logic [7:0] p0_ext, p1_ext, p0_o, p0_oe, p1_o, p1_oe, r0, r1;
  int fails, comparisons;
  wire logic sda_line = !(sda_oe | sda_pull);
  wire logic [7:0] p0_pin = (p0_oe & p0_o) | (~p0_oe & p0_ext);
  wire logic [7:0] p1_pin = (p1_oe & p1_o) | (~p1_oe & p1_ext);
  iox_bus_master i_master (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));
  // straps tied firmly for the whole run
  iox_expander i_dut (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_bit0(1'b1),
    .addr_strap_bit1(1'b0), .addr_strap_bit2(1'b1), .port_zero_pins_i(p0_pin),
    .port_zero_pins_o(p0_o), .port_zero_pins_oe(p0_oe), .port_one_pins_i(p1_pin),
    .port_one_pins_o(p1_o), .port_one_pins_oe(p1_oe), .irq_o(irq_o), .irq_oe(irq_oe),
    .apply_hold(apply_hold));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #7;
    forever #32 clk_link = ~clk_link;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle();
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] q [4];
    q = '{8'h4a, p, a, b};
    ok = 1'b1;
    i_master.start();
    foreach (q[i]) begin
      i_master.send(q[i], ack);
      ok &= ack;
    end
    i_master.stop();
    chk("write_ack", 16'h1, {15'h0, ok});
    settle();
  endtask
  // one byte by default, so a read touches a single port; two exercises master ack
  task automatic rd(input logic [7:0] p, input logic two = 1'b0);
    i_master.start();
    i_master.send(8'h4a, ack);
    i_master.send(p, ack);
    i_master.start();
    i_master.send(8'h4b, ack);
    if (two) begin
      i_master.recv(1'b1, r1);
    end
    i_master.recv(1'b0, r0);
    i_master.stop();
    settle();
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    // traffic needs about 1.73 ms, this keeps a hang under 100k cycles
    #1900000;
    fails++;
    summarize();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    fails = 0;
    comparisons = 0;
    rstn = 1'b0;
    apply_hold = 1'b0;
    p0_ext = 8'h00;
    p1_ext = 8'h00;
    repeat (2) @(posedge clk_link);
    @(negedge clk_sys) rstn = 1'b1;
    repeat (50) @(negedge clk_sys);
    chk("pins_o", 16'hffff, {p1_o, p0_o});
    chk("pins_oe", 16'h0000, {p1_oe, p0_oe});
    chk("drive_low", 16'h0, {14'h0, sda_o, irq_o});
    wr(8'h06, 8'h00, 8'hf0);
    wr(8'h02, 8'ha5, 8'h3c);
    chk("pins_o", 16'h3ca5, {p1_o, p0_o});
    chk("pins_oe", 16'h0fff, {p1_oe, p0_oe});
    i_master.start();
    i_master.send(8'h4e, ack);
    i_master.stop();
    chk("foreign_ack", 16'h0, {15'h0, ack});
    @(negedge clk_sys) p1_ext = 8'h50;
    settle();
    chk("irq_raise", 16'h1, {15'h0, irq_oe});
    @(negedge clk_sys) p1_ext = 8'h00;
    settle();
    chk("irq_return", 16'h0, {15'h0, irq_oe});
    @(negedge clk_sys) p1_ext = 8'h50;
    rd(8'h00);
    chk("in_port0", 16'h00a5, {8'h00, r0});
    chk("irq_other_port", 16'h1, {15'h0, irq_oe});
    rd(8'h01);
    chk("in_port1", 16'h005c, {8'h00, r0});
    chk("irq_own_port", 16'h0, {15'h0, irq_oe});
    wr(8'h04, 8'hff, 8'h00);
    rd(8'h00);
    chk("in_inverted", 16'h005a, {8'h00, r0});
    @(negedge clk_sys) p0_ext = 8'hff;
    wr(8'h06, 8'hff, 8'hf0);
    chk("pins_oe", 16'h0f00, {p1_oe, p0_oe});
    chk("irq_dir_switch", 16'h1, {15'h0, irq_oe});
    rd(8'h00);
    chk("in_port0", 16'h0000, {8'h00, r0});
    chk("irq_cleared", 16'h0, {15'h0, irq_oe});
    @(negedge clk_sys) apply_hold = 1'b1;
    i_master.start();
    i_master.send(8'h4a, ack);
    i_master.send(8'h02, ack);
    for (int i = 0; i < 40 && ack; i++) i_master.send(i[7:0], ack);
    i_master.stop();
    chk("fifo_refuse", 16'h0, {15'h0, ack});
    @(negedge clk_sys) apply_hold = 1'b0;
    // 33 queued events drain one per clock
    repeat (48) @(negedge clk_sys);
    chk("fifo_drain", 16'h1d1e, {p1_o, p0_o});
    wr(8'h02, 8'h11, 8'h22);
    chk("pins_o", 16'h2211, {p1_o, p0_o});
    rd(8'h02, 1'b1);
    chk("out_readback", 16'h2211, {r0, r1});
    rd(8'h04, 1'b1);
    chk("pol_readback", 16'h00ff, {r0, r1});
    summarize();
  end
endmodule
`default_nettype wire
